/* File: core/pca_pwm_consts.svh */
// Purpose: Addresses, field positions, reset values and codes of the PWM setup register.
// Assumes: Included by its bare name from the design modules and the testbench.
// Notes: Definitions only.
`ifndef PCA_PWM_CONSTS_SVH
`define PCA_PWM_CONSTS_SVH

`define PWM_SETUP_ADDR 8'hD9
`define PWM_SETUP_PAGE 8'h0F
`define PWM_SETUP_RESET 8'h00

`define VIEW_SEL_BIT 7
`define WRAP_IRQ_EN_BIT 6
`define WRAP_FLAG_BIT 5
`define RSVD_HI_BIT 4
`define RSVD_LO_BIT 2
`define CYC_SEL_HI_BIT 1
`define CYC_SEL_LO_BIT 0

`define CYC_SEL_8 2'h0
`define CYC_SEL_9 2'h1
`define CYC_SEL_10 2'h2
`define CYC_SEL_11 2'h3

`define CYC_BITS_BASE 5'h08
`define CYC_BITS_WIDE 5'h10
`define RSVD_READ 3'h0

`endif

/* File: core/pca_pwm_pkg.sv */
// Purpose: Shared types for the PWM cycle configuration block.
// Assumes: Constants come from the header.
// Notes: Types only.
package pca_pwm_pkg;
  typedef logic [7:0] sfr_byte_t;
  typedef logic [1:0] cycle_sel_t;
  typedef logic [4:0] cycle_bits_t;
endpackage

/* File: core/cycle_wrap_detect.sv */
// Purpose: Spot the counter step that carries out of the selected cycle bit.
// Assumes: Count and step strobe come from the counter on the same clock.
// Notes: Purely combinational; the caller registers the result into the flag.
`timescale 1ns/1ns
`include "pca_pwm_consts.svh"
module cycle_wrap_detect
  import pca_pwm_pkg::*;
#(
  parameter int COUNT_W = 16
) (
  input wire logic [COUNT_W-1:0] i_count,
  input wire logic i_step,
  input wire cycle_sel_t i_sel,
  output logic o_wrap
);
  // The carry leaves bit N-1 exactly when the low N bits are all ones as the counter steps.
  always_comb begin
    o_wrap = 1'b0;
    case (i_sel)
      `CYC_SEL_8: o_wrap = i_step && (&i_count[7:0]); // RULE5
      `CYC_SEL_9: o_wrap = i_step && (&i_count[8:0]); // RULE5
      `CYC_SEL_10: o_wrap = i_step && (&i_count[9:0]); // RULE5
      default: o_wrap = i_step && (&i_count[10:0]); // RULE5
    endcase
  end
endmodule

/* File: core/pca_pwm_cycle_config.sv */
// Purpose: Shared PWM setup register of the counter array and its effects.
// Assumes: Special-function bus, counter and module modes share i_clk.
// Notes: Read data appears one clock after the read strobe.
`timescale 1ns/1ns
`include "pca_pwm_consts.svh"
// Operation
// RULE1 - Register answers only at 0xD9, page 0x0F
// RULE2 - View bit steers module values to reload registers
// RULE3 - Reload registers act only in 9-11 bit PWM
// RULE4 - Flag raises interrupt only when enabled
// RULE5 - Flag set on carry from selected bit
// RULE6 - Flag set by hardware or software, software clears
// RULE7 - Bits 4:2 read zero, writes ignored
// RULE8 - Select 00..11 means 8..11 bit cycle
// RULE9 - Cycle length applies to non-wide PWM channels
// RULE10 - Wide enable selects 16-bit PWM per module
// RULE11 - Reset clears every writable bit
module pca_pwm_cycle_config
  import pca_pwm_pkg::*;
#(
  parameter int NUM_MODULES = 6,
  parameter int COUNT_W = 16
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire sfr_byte_t i_sfr_addr,
  input wire sfr_byte_t i_sfr_page,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire sfr_byte_t i_sfr_wdata,
  output sfr_byte_t o_sfr_rdata,
  output logic o_sfr_hit,
  input wire logic [COUNT_W-1:0] i_main_array_counter,
  input wire logic i_counter_step,
  input wire logic i_module_value_access,
  output logic o_compare_access,
  output logic o_reload_access,
  input wire logic [NUM_MODULES-1:0] i_pwm_enable,
  input wire logic [NUM_MODULES-1:0] i_wide_pwm_enable,
  output logic [NUM_MODULES-1:0] o_reload_active,
  output logic [NUM_MODULES*5-1:0] o_module_cycle_bits,
  output logic o_reload_view_select,
  output logic o_cycle_wrap_irq_enable,
  output logic o_cycle_wrap_flag,
  output cycle_sel_t o_cycle_length_select,
  output logic o_cycle_irq
);

  logic reload_view_select_q;
  logic reload_view_select_d;
  logic cycle_wrap_irq_enable_q;
  logic cycle_wrap_irq_enable_d;
  logic cycle_wrap_flag_q;
  logic cycle_wrap_flag_d;
  cycle_sel_t cycle_length_select_q;
  cycle_sel_t cycle_length_select_d;
  sfr_byte_t rdata_q;
  sfr_byte_t rdata_d;
  sfr_byte_t setup_view;
  logic [NUM_MODULES*5-1:0] cycle_bits_q;
  logic [NUM_MODULES*5-1:0] cycle_bits_d;
  logic hit;
  logic setup_wr;
  logic wrap;

  always_comb begin
    hit = (i_sfr_addr == `PWM_SETUP_ADDR) && (i_sfr_page == `PWM_SETUP_PAGE); // RULE1
  end

  assign setup_wr = hit && i_sfr_wr;
  assign o_sfr_hit = hit;

  cycle_wrap_detect #(
    .COUNT_W(COUNT_W)
  ) u_wrap (
    .i_count(i_main_array_counter),
    .i_step(i_counter_step),
    .i_sel(cycle_length_select_q),
    .o_wrap(wrap)
  );

  // The reserved field is pinned to zero here, so a write can never leak into it.
  always_comb begin
    setup_view = `PWM_SETUP_RESET;
    setup_view[`VIEW_SEL_BIT] = reload_view_select_q;
    setup_view[`WRAP_IRQ_EN_BIT] = cycle_wrap_irq_enable_q;
    setup_view[`WRAP_FLAG_BIT] = cycle_wrap_flag_q;
    setup_view[`RSVD_HI_BIT:`RSVD_LO_BIT] = `RSVD_READ; // RULE7
    setup_view[`CYC_SEL_HI_BIT:`CYC_SEL_LO_BIT] = cycle_length_select_q;
  end

  always_comb begin
    reload_view_select_d = reload_view_select_q;
    cycle_wrap_irq_enable_d = cycle_wrap_irq_enable_q;
    cycle_wrap_flag_d = cycle_wrap_flag_q;
    cycle_length_select_d = cycle_length_select_q;
    rdata_d = `PWM_SETUP_RESET;
    if (setup_wr) begin
      reload_view_select_d = i_sfr_wdata[`VIEW_SEL_BIT];
      cycle_wrap_irq_enable_d = i_sfr_wdata[`WRAP_IRQ_EN_BIT];
      cycle_wrap_flag_d = i_sfr_wdata[`WRAP_FLAG_BIT]; // RULE6
      cycle_length_select_d = i_sfr_wdata[`CYC_SEL_HI_BIT:`CYC_SEL_LO_BIT]; // RULE8
    end
    // A carry in the same cycle as a software clear must not be lost, so set wins.
    if (wrap) begin
      cycle_wrap_flag_d = 1'b1; // RULE5 RULE6
    end
    if (hit && i_sfr_rd) begin
      rdata_d = setup_view; // RULE7
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      reload_view_select_q <= 1'b0; // RULE11
      cycle_wrap_irq_enable_q <= 1'b0;
      cycle_wrap_flag_q <= 1'b0;
      cycle_length_select_q <= `CYC_SEL_8;
      rdata_q <= `PWM_SETUP_RESET;
    end else begin
      reload_view_select_q <= reload_view_select_d;
      cycle_wrap_irq_enable_q <= cycle_wrap_irq_enable_d;
      cycle_wrap_flag_q <= cycle_wrap_flag_d;
      cycle_length_select_q <= cycle_length_select_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_sfr_rdata = rdata_q;
  assign o_reload_view_select = reload_view_select_q;
  assign o_cycle_wrap_irq_enable = cycle_wrap_irq_enable_q;
  assign o_cycle_wrap_flag = cycle_wrap_flag_q;
  assign o_cycle_length_select = cycle_length_select_q;
  assign o_cycle_irq = cycle_wrap_irq_enable_q && cycle_wrap_flag_q; // RULE4

  // Accesses at the module value addresses land in one of two register sets.
  assign o_compare_access = i_module_value_access && !reload_view_select_q; // RULE2
  assign o_reload_access = i_module_value_access && reload_view_select_q; // RULE2

  // Per module: cycle length in bits. One process owns the whole vector, so no
  // slice of it ever has a second driver.
  always_comb begin
    cycle_bits_d = cycle_bits_q;
    for (int k = 0; k < NUM_MODULES; k++) begin
      if (i_wide_pwm_enable[k]) begin
        cycle_bits_d[k*5 +: 5] = `CYC_BITS_WIDE; // RULE10
      end else begin
        cycle_bits_d[k*5 +: 5] = `CYC_BITS_BASE + {3'h0, cycle_length_select_q}; // RULE8 RULE9
      end
    end
  end

  // Per module: whether its reload register matters.
  genvar m;
  generate
    for (m = 0; m < NUM_MODULES; m++) begin : g_mod
      // The reload value is meaningless in 8-bit and 16-bit cycles.
      assign o_reload_active[m] = i_pwm_enable[m] && !i_wide_pwm_enable[m] &&
        (cycle_length_select_q != `CYC_SEL_8); // RULE3
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cycle_bits_q <= {NUM_MODULES{`CYC_BITS_BASE}};
    end else begin
      cycle_bits_q <= cycle_bits_d;
    end
  end

  assign o_module_cycle_bits = cycle_bits_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  a_page_decode: assert property ( // RULE1
    (i_sfr_wr && i_sfr_page != `PWM_SETUP_PAGE) |=>
      $stable({reload_view_select_q, cycle_wrap_irq_enable_q, cycle_length_select_q}))
    else $error("setup register changed by a write on another page");

  a_view_mapping: assert property ( // RULE2
    i_module_value_access |->
      (o_reload_access == o_reload_view_select) && (o_compare_access != o_reload_view_select))
    else $error("module value access routed to the wrong register set");

  a_reload_use: assert property ( // RULE3
    o_reload_active[0] |-> i_pwm_enable[0] && !i_wide_pwm_enable[0] &&
      (o_cycle_length_select != `CYC_SEL_8))
    else $error("reload register active outside 9 to 11 bit PWM");

  a_irq_gate: assert property ( // RULE4
    (setup_wr && !i_sfr_wdata[`WRAP_IRQ_EN_BIT]) |=> !o_cycle_irq)
    else $error("cycle interrupt raised while disabled");

  a_wrap_sets: assert property ( // RULE5
    (i_counter_step && (&i_main_array_counter[8:0]) && o_cycle_length_select == `CYC_SEL_9)
      |=> o_cycle_wrap_flag ##0 (o_cycle_irq == o_cycle_wrap_irq_enable))
    else $error("nine bit carry did not set the flag");

  a_flag_sticky: assert property ( // RULE6
    (o_cycle_wrap_flag && !setup_wr) |=> o_cycle_wrap_flag)
    else $error("flag cleared without a software write");

  a_sw_clear: assert property ( // RULE6
    (setup_wr && !i_sfr_wdata[`WRAP_FLAG_BIT] && !wrap) |=> !o_cycle_wrap_flag)
    else $error("software write of zero did not clear the flag");

  a_reserved_zero: assert property ( // RULE7
    (hit && i_sfr_rd) |=> (o_sfr_rdata[`RSVD_HI_BIT:`RSVD_LO_BIT] == `RSVD_READ) &&
      // A write in the read's cycle lands after the read, so the old select is expected.
      (o_sfr_rdata[`CYC_SEL_HI_BIT:`CYC_SEL_LO_BIT] == $past(o_cycle_length_select)))
    else $error("reserved bits read nonzero or select misread");

  a_cycle_len: assert property ( // RULE9
    (!i_wide_pwm_enable[0]) |=>
      o_module_cycle_bits[4:0] == `CYC_BITS_BASE + {3'h0, $past(o_cycle_length_select)})
    else $error("narrow module cycle length does not follow the select");

  a_wide_len: assert property ( // RULE10
    i_wide_pwm_enable[0] |=> o_module_cycle_bits[4:0] == `CYC_BITS_WIDE)
    else $error("wide module not given a sixteen bit cycle");

  a_reset_clear: assert property ( // RULE11
    $rose(i_reset_n) |-> setup_view == `PWM_SETUP_RESET)
    else $error("setup register not cleared by reset");

  c_wrap_event: cover property (wrap ##1 o_cycle_irq);
  c_sw_clear: cover property (o_cycle_wrap_flag ##1 setup_wr ##1 !o_cycle_wrap_flag);
  c_reload_access: cover property (o_reload_access);
  c_read_hit: cover property (hit && i_sfr_rd);

endmodule

/* File: sim/pca_pwm_cycle_config_tb.sv */
// Purpose: Self-checking bench for the shared PWM setup register and its effects.
// Assumes: Inputs change on the rising edge by non-blocking assignment.
// Notes: Outputs are sampled 1 ns after a rising edge, or at the falling edge in t_view, so that edge's updates have landed first.
`timescale 1ns/1ns
`include "pca_pwm_consts.svh"
module pca_pwm_cycle_config_tb import pca_pwm_pkg::*; ;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  sfr_byte_t addr = 8'h00, page = 8'h00, wdata = 8'h00, rdata, got;
  logic wr = 1'b0, rd = 1'b0, step = 1'b0, mod_acc = 1'b0;
  logic hit, hit_seen, cmp_acc, rld_acc, view, irq_en, flag, irq;
  logic [15:0] cnt = 16'h0000;
  logic [5:0] pwm_en = 6'h1F, wide_en = 6'h00, rld_act;
  logic [29:0] cyc_bits;
  cycle_sel_t sel_o;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;

  pca_pwm_cycle_config i_dut (.i_clk(clk), .i_reset_n(reset_n), .i_sfr_addr(addr),
    .i_sfr_page(page), .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_wdata(wdata),
    .o_sfr_rdata(rdata), .o_sfr_hit(hit), .i_main_array_counter(cnt),
    .i_counter_step(step), .i_module_value_access(mod_acc), .o_compare_access(cmp_acc),
    .o_reload_access(rld_acc), .i_pwm_enable(pwm_en), .i_wide_pwm_enable(wide_en),
    .o_reload_active(rld_act), .o_module_cycle_bits(cyc_bits),
    .o_reload_view_select(view), .o_cycle_wrap_irq_enable(irq_en),
    .o_cycle_wrap_flag(flag), .o_cycle_length_select(sel_o), .o_cycle_irq(irq));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic sfr_write(input sfr_byte_t a, input sfr_byte_t p, input sfr_byte_t d);
    @(posedge clk);
    addr <= a;
    page <= p;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic sfr_read(input sfr_byte_t a, input sfr_byte_t p);
    @(posedge clk);
    addr <= a;
    page <= p;
    rd <= 1'b1;
    #1 hit_seen = hit;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask

  task automatic counter_step(input logic [15:0] c);
    @(posedge clk);
    cnt <= c;
    step <= 1'b1;
    @(posedge clk);
    step <= 1'b0;
    #1;
  endtask

  task automatic t_reset();
    sfr_read(`PWM_SETUP_ADDR, `PWM_SETUP_PAGE);
    check("reset read", got, 8'h00);
    check("reset fields", {view, irq_en, flag, sel_o, irq}, 6'h00);
    check("reset cycle bits", cyc_bits, {6{5'h08}});
  endtask

  task automatic t_fields();
    sfr_write(`PWM_SETUP_ADDR, `PWM_SETUP_PAGE, 8'hFF);
    sfr_read(`PWM_SETUP_ADDR, `PWM_SETUP_PAGE);
    check("hit", hit_seen, 1'b1);
    check("read all ones", got, 8'hE3);
    check("field outputs", {view, irq_en, flag, sel_o}, 5'h1F);
    check("irq enabled", irq, 1'b1);
    sfr_write(`PWM_SETUP_ADDR, `PWM_SETUP_PAGE, 8'h80);
    sfr_read(`PWM_SETUP_ADDR, `PWM_SETUP_PAGE);
    check("flag cleared", got, 8'h80);
    check("irq masked", irq, 1'b0);
  endtask

  task automatic t_decode();
    sfr_write(`PWM_SETUP_ADDR, 8'h00, 8'h43);
    sfr_write(8'hD8, `PWM_SETUP_PAGE, 8'h43);
    sfr_read(`PWM_SETUP_ADDR, `PWM_SETUP_PAGE);
    check("foreign writes", got, 8'h80);
    sfr_read(`PWM_SETUP_ADDR, 8'h00);
    check("wrong page read", {hit_seen, got}, 9'h000);
  endtask

  task automatic t_view();
    @(posedge clk);
    mod_acc <= 1'b1;
    @(negedge clk);
    check("reload view", {rld_acc, cmp_acc}, 2'b10);
    sfr_write(`PWM_SETUP_ADDR, `PWM_SETUP_PAGE, 8'h00);
    @(negedge clk);
    check("compare view", {rld_acc, cmp_acc}, 2'b01);
    @(posedge clk);
    mod_acc <= 1'b0;
    wide_en <= 6'h05;
  endtask

  // The odd selections also enable the interrupt, so both irq outcomes are seen.
  task automatic t_cycle(input logic [1:0] s);
    logic [4:0] e;
    sfr_write(`PWM_SETUP_ADDR, `PWM_SETUP_PAGE, {1'b0, s[0], 4'h0, s});
    @(posedge clk);
    #1 check("select", sel_o, s);
    check("reload active", rld_act, pwm_en & ~wide_en & {6{s != 2'h0}});
    for (int m = 0; m < 6; m++) begin
      e = wide_en[m] ? 5'h10 : 5'h08 + 5'(s);
      check("cycle bits", cyc_bits[5*m +: 5], e);
    end
    counter_step(16'((32'h1 << (7 + s)) - 1));
    check("short carry", flag, 1'b0);
    counter_step(16'((32'h1 << (8 + s)) - 1));
    check("wrap flag", flag, 1'b1);
    check("wrap irq", irq, s[0]);
    repeat (3) @(posedge clk);
    #1 check("flag holds", flag, 1'b1);
    sfr_write(`PWM_SETUP_ADDR, `PWM_SETUP_PAGE, {6'h00, s});
    #1 check("flag clear", flag, 1'b0);
  endtask

  task automatic t_set_wins();
    @(posedge clk);
    cnt <= 16'h07FF;
    step <= 1'b1;
    wdata <= 8'h03;
    wr <= 1'b1;
    @(posedge clk);
    step <= 1'b0;
    wr <= 1'b0;
    #1 check("set over clear", flag, 1'b1);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      close_out();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_fields();
    t_decode();
    t_view();
    for (int s = 0; s < 4; s++) begin
      t_cycle(2'(s));
    end
    t_set_wins();
    close_out();
  end
endmodule
